// ---- rtl/sdram_pins_pkg.sv ----
// constants for the synchronous dram pin interface
package sdram_pins_pkg;
  localparam int ADDR_W = 12;
  localparam int ROW_W = 12;
  localparam int COL_W = 8;
  localparam int BANK_W = 2;
  localparam int NUM_BANKS = 4;
  localparam int DATA_W = 32;
  localparam int MASK_W = 4;
  localparam int BYTE_W = 8;
  localparam int PRE_ALL_BIT = 10;
  localparam int READ_MASK_LATENCY = 2;
  localparam int CAS_LATENCY = 2;
  localparam int MEM_DEPTH = 256;
  localparam int MEM_AW = 8;
  localparam logic [ROW_W-1:0] ROW_RESET = 12'h000;

  typedef enum logic [2:0] {
    CMD_MRS, CMD_REFRESH, CMD_PRECHARGE, CMD_ACTIVATE,
    CMD_WRITE, CMD_READ, CMD_STOP, CMD_NOP
  } cmd_e;

  typedef enum logic [1:0] {PWR_ACTIVE, PWR_DOWN, PWR_SUSPEND, PWR_SELF_REFRESH} pwr_e;
endpackage

// ---- rtl/cmd_decode.sv ----
// command decoder for the strobe pins
`timescale 1ns/1ps
`default_nettype none
module cmd_decode (
  input wire logic chipSelB,
  input wire logic rowStrobeB,
  input wire logic colStrobeB,
  input wire logic writeSelB,
  output var sdram_pins_pkg::cmd_e cmd
);
  import sdram_pins_pkg::*;
  always_comb begin
    if (chipSelB) begin
      cmd = CMD_NOP;
    end else begin
      unique case ({rowStrobeB, colStrobeB, writeSelB})
        3'b000: cmd = CMD_MRS;
        3'b001: cmd = CMD_REFRESH;
        3'b010: cmd = CMD_PRECHARGE;
        3'b011: cmd = CMD_ACTIVATE;
        3'b100: cmd = CMD_WRITE;
        3'b101: cmd = CMD_READ;
        3'b110: cmd = CMD_STOP;
        3'b111: cmd = CMD_NOP;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- rtl/sdram_pin_interface.sv ----
// device-side pin logic of a four-bank synchronous dram
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Row address uses all 12 address pins, column address uses the low 8 of them.
// - On precharge, address bit ten picks all banks or only the selected bank.
// - Bank select names the bank to open on activate and the bank to access on read or write.
// - With chip select high, new commands are ignored while ongoing work continues.
// - The operation is decoded from row strobe, column strobe and write select at the edge.
// - A mask sampled high during a read turns that byte's drivers off two cycles later.
// - A mask sampled high during a write blocks that byte in the same cycle.
// - All inputs are captured on the rising clock edge only.
// - Clock enable low stops internal clocking and enters power down, suspend or self refresh.
// - The data bus is shared; the device drives it only for read data.
// - Each of the four masks governs one byte of the 32-bit bus independently.
module sdram_pin_interface (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clockEnable,
  input wire logic chipSelB,
  input wire logic rowStrobeB,
  input wire logic colStrobeB,
  input wire logic writeSelB,
  input wire logic [sdram_pins_pkg::BANK_W-1:0] bank_sel,
  input wire logic [sdram_pins_pkg::ADDR_W-1:0] mux_address,
  input wire logic [sdram_pins_pkg::MASK_W-1:0] byte_mask,
  input wire logic [sdram_pins_pkg::DATA_W-1:0] dataBusIn,
  output logic [sdram_pins_pkg::DATA_W-1:0] dataBusOut,
  output logic [sdram_pins_pkg::MASK_W-1:0] dataBusOeB,
  output logic [1:0] powerState,
  output logic [sdram_pins_pkg::NUM_BANKS-1:0] bankOpen
);
  import sdram_pins_pkg::*;

  // ----------------------------------------
  // storage and decode
  // ----------------------------------------
  // one page of columns per bank; rows not kept apart
  logic [DATA_W-1:0] mem [NUM_BANKS][MEM_DEPTH];
  logic [ROW_W-1:0] openRow_reg [NUM_BANKS];
  cmd_e cmd;
  cmd_e cmdLive;
  pwr_e pwr_reg;
  pwr_e pwr_next;
  logic [NUM_BANKS-1:0] bankOpen_reg;
  logic [MASK_W-1:0] maskPipe_reg [READ_MASK_LATENCY];
  logic [DATA_W-1:0] rdPipe_reg [CAS_LATENCY];
  logic [CAS_LATENCY-1:0] rdValid_reg;
  logic [DATA_W-1:0] dataOut_reg;
  logic [MASK_W-1:0] oeB_reg;
  logic clkOn;

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  function automatic logic [MEM_AW-1:0] colOf(input logic [ADDR_W-1:0] a);
    return a[COL_W-1:0];
  endfunction

  function automatic logic bankReady(input logic [NUM_BANKS-1:0] openFlags,
      input logic [BANK_W-1:0] b);
    return openFlags[b];
  endfunction

  function automatic logic floatsByte(input logic valid, input logic masked,
      input logic busTaken);
    // high turns the byte driver off
    return !valid || masked || busTaken;
  endfunction

  function automatic logic [DATA_W-1:0] mergeBytes(input logic [DATA_W-1:0] oldW,
      input logic [DATA_W-1:0] newW, input logic [MASK_W-1:0] m);
    logic [DATA_W-1:0] r;
    r = oldW;
    for (int i = 0; i < MASK_W; i++) begin
      if (!m[i]) begin
        r[i*BYTE_W +: BYTE_W] = newW[i*BYTE_W +: BYTE_W];
      end
    end
    return r;
  endfunction

  cmd_decode u_decode (
    .chipSelB(chipSelB),
    .rowStrobeB(rowStrobeB),
    .colStrobeB(colStrobeB),
    .writeSelB(writeSelB),
    .cmd(cmd)
  );

  // ----------------------------------------
  // power state
  // ----------------------------------------
  // commands are dropped while clocking is off
  assign clkOn = (pwr_reg == PWR_ACTIVE) && clockEnable;
  assign cmdLive = clkOn ? cmd : CMD_NOP;

  // a read in flight picks suspend so its pipeline freezes
  always_comb begin
    pwr_next = pwr_reg;
    unique case (pwr_reg)
      PWR_ACTIVE: begin
        if (!clockEnable) begin
          if (cmd == CMD_REFRESH) begin
            pwr_next = PWR_SELF_REFRESH;
          end else if (rdValid_reg != '0) begin
            pwr_next = PWR_SUSPEND;
          end else begin
            pwr_next = PWR_DOWN;
          end
        end
      end
      PWR_DOWN, PWR_SUSPEND, PWR_SELF_REFRESH: begin
        if (clockEnable) begin
          pwr_next = PWR_ACTIVE;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pwr_reg <= PWR_ACTIVE;
    end else begin
      pwr_reg <= pwr_next;
    end
  end

  // ----------------------------------------
  // bank tracking
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      bankOpen_reg <= '0;
      for (int b = 0; b < NUM_BANKS; b++) begin
        openRow_reg[b] <= ROW_RESET;
      end
    end else begin
      // one command per edge, so open and close never collide
      unique case (cmdLive)
        CMD_ACTIVATE: begin
          bankOpen_reg[bank_sel] <= 1'b1;
          openRow_reg[bank_sel] <= mux_address[ROW_W-1:0];
        end
        CMD_PRECHARGE: begin
          // address bit ten widens the close to every bank
          if (mux_address[PRE_ALL_BIT]) begin
            bankOpen_reg <= '0;
          end else begin
            bankOpen_reg[bank_sel] <= 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // write path
  // ----------------------------------------
  always_ff @(posedge clock) begin
    // masked bytes keep their old contents
    if (clkOn && cmdLive == CMD_WRITE && bankReady(bankOpen_reg, bank_sel)) begin
      mem[bank_sel][colOf(mux_address)] <=
        mergeBytes(mem[bank_sel][colOf(mux_address)], dataBusIn, byte_mask);
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rdValid_reg <= '0;
      for (int i = 0; i < CAS_LATENCY; i++) begin
        rdPipe_reg[i] <= '0;
      end
      for (int i = 0; i < READ_MASK_LATENCY; i++) begin
        maskPipe_reg[i] <= '1;
      end
    end else if (clkOn) begin
      // pipeline holds while the clock is stopped
      rdValid_reg[0] <= (cmdLive == CMD_READ) && bankReady(bankOpen_reg, bank_sel);
      rdPipe_reg[0] <= mem[bank_sel][colOf(mux_address)];
      maskPipe_reg[0] <= byte_mask;
      for (int i = 1; i < CAS_LATENCY; i++) begin
        rdValid_reg[i] <= rdValid_reg[i-1];
        rdPipe_reg[i] <= rdPipe_reg[i-1];
      end
      for (int i = 1; i < READ_MASK_LATENCY; i++) begin
        maskPipe_reg[i] <= maskPipe_reg[i-1];
      end
    end
  end

  // ----------------------------------------
  // data bus drivers
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      dataOut_reg <= '0;
      oeB_reg <= '1;
    end else if (clkOn) begin
      // drivers hold their last state while the clock is stopped
      dataOut_reg <= rdPipe_reg[CAS_LATENCY-1];
      for (int i = 0; i < MASK_W; i++) begin
        // a write on this edge hands the bus to the controller
        oeB_reg[i] <= floatsByte(rdValid_reg[CAS_LATENCY-1],
          maskPipe_reg[READ_MASK_LATENCY-1][i], cmdLive == CMD_WRITE);
      end
    end
  end

  // ----------------------------------------
  // pin outputs
  // ----------------------------------------
  assign dataBusOut = dataOut_reg;
  assign dataBusOeB = oeB_reg;
  assign powerState = pwr_reg;
  assign bankOpen = bankOpen_reg;
endmodule
`default_nettype wire

// ---- dv/ctrl_model.sv ----
// memory controller model driving the pins
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
  input wire logic clock,
  output logic cke = 1'b1,
  output logic [3:0] st = 4'hF,
  output logic [1:0] bank = 2'h0,
  output logic [11:0] addr = 12'h000,
  output logic [3:0] mask = 4'hF,
  output logic [31:0] dq = 32'h0000_0000
);
  // one command per edge; bus toggles unless writing
  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
                     input logic [3:0] m, input logic [31:0] d, input logic e);
    @(posedge clock);
    cke <= e;
    st <= c;
    bank <= b;
    addr <= a;
    mask <= m;
    dq <= (c == 4'h4) ? d : ~dq;
  endtask
endmodule
`default_nettype wire

// ---- dv/sdram_pin_interface_chk.sv ----
// assertions on the dram pin ports
`timescale 1ns/1ps
`default_nettype none
module sdram_pin_interface_chk (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clockEnable,
  input wire logic chipSelB,
  input wire logic rowStrobeB,
  input wire logic colStrobeB,
  input wire logic writeSelB,
  input wire logic [1:0] bank_sel,
  input wire logic [11:0] mux_address,
  input wire logic [3:0] byte_mask,
  input wire logic [3:0] dataBusOeB,
  input wire logic [1:0] powerState,
  input wire logic [3:0] bankOpen
);
  logic go;
  logic rd;
  logic [2:0] op;
  assign go = !chipSelB && clockEnable && powerState == 2'h0;
  assign op = {rowStrobeB, colStrobeB, writeSelB};
  assign rd = go && op == 3'h5 && bankOpen[bank_sel];
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_read_float: assert property (rd ##1 clockEnable ##1 (clockEnable && !(go && op == 3'h4))
    |=> dataBusOeB == $past(byte_mask, 3)) else $error("read mask float wrong");
  a_idle_float: assert property (!rd && clockEnable && powerState == 2'h0 ##1
    clockEnable && powerState == 2'h0 ##1 clockEnable && powerState == 2'h0
    |=> dataBusOeB == 4'hF) else $error("bus driven");
  a_deselect_hold: assert property (chipSelB |=> $stable(bankOpen))
    else $error("deselected command acted");
  a_activate_opens: assert property (go && op == 3'h3 |=> bankOpen[$past(bank_sel)])
    else $error("bank not opened");
  a_pre_all: assert property (go && op == 3'h2 && mux_address[10] |=> bankOpen == 4'h0)
    else $error("precharge all failed");
  a_pre_one: assert property (go && op == 3'h2 && !mux_address[10] |=>
    bankOpen == ($past(bankOpen) & ~(4'h1 << $past(bank_sel)))) else $error("precharge one");
  a_pwr_enter: assert property (!clockEnable && powerState == 2'h0 |=> powerState != 2'h0)
    else $error("no low power entry");
  a_pwr_exit: assert property (clockEnable && powerState != 2'h0 |=> powerState == 2'h0)
    else $error("no low power exit");
endmodule
bind sdram_pin_interface sdram_pin_interface_chk u_chk (.clock, .rst_b, .clockEnable,
  .chipSelB, .rowStrobeB, .colStrobeB, .writeSelB, .bank_sel, .mux_address, .byte_mask,
  .dataBusOeB, .powerState, .bankOpen);
`default_nettype wire

// ---- dv/sdram_pin_interface_test.sv ----
// self-checking bench for the dram pin interface
`timescale 1ns/1ps
`default_nettype none
module sdram_pin_interface_test;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic cke;
  logic [3:0] st, mask, oeB, banks;
  logic [1:0] bank, pwr;
  logic [11:0] addr;
  logic [31:0] dq, rdata;
  int failures = 0;
  int n_checks = 0;
  always #4 clock = ~clock;
  ctrl_model u_ctrl_model (.clock, .cke, .st, .bank, .addr, .mask, .dq);
  sdram_pin_interface u_sdram_pin_interface (.clock, .rst_b, .clockEnable(cke),
    .chipSelB(st[3]), .rowStrobeB(st[2]), .colStrobeB(st[1]), .writeSelB(st[0]),
    .bank_sel(bank), .mux_address(addr), .byte_mask(mask), .dataBusIn(dq),
    .dataBusOut(rdata), .dataBusOeB(oeB), .powerState(pwr), .bankOpen(banks));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic go(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
                    input logic [3:0] m, input logic [31:0] d);
    u_ctrl_model.cmd(c, b, a, m, d, 1'b1);
  endtask
  task automatic idle(input int n);
    repeat (n) go(4'hF, 2'h0, 12'h000, 4'hF, 32'h0000_0000);
  endtask
  task automatic t_bank();
    go(4'h3, 2'h2, 12'hFFF, 4'hF, 32'h0000_0000);
    go(4'hB, 2'h1, 12'h000, 4'hF, 32'h0000_0000);
    go(4'h3, 2'h0, 12'h000, 4'hF, 32'h0000_0000);
    idle(1);
    #1 chk(banks, 4'h5);
    go(4'h2, 2'h2, 12'h000, 4'hF, 32'h0000_0000);
    idle(1);
    #1 chk(banks, 4'h1);
    go(4'h3, 2'h3, 12'h000, 4'hF, 32'h0000_0000);
    go(4'h2, 2'h1, 12'h400, 4'hF, 32'h0000_0000);
    idle(1);
    #1 chk(banks, 4'h0);
    go(4'h5, 2'h1, 12'h000, 4'h0, 32'h0000_0000);
    idle(3);
    #1 chk(oeB, 4'hF);
    $display("t_bank done");
  endtask
  task automatic t_mask();
    go(4'h3, 2'h2, 12'hFFF, 4'hF, 32'h0000_0000);
    go(4'h4, 2'h2, 12'h0FF, 4'h0, 32'h1122_3344);
    go(4'h4, 2'h2, 12'h0FF, 4'h5, 32'hAABB_CCDD);
    go(4'h5, 2'h2, 12'h8FF, 4'h2, 32'h0000_0000);
    idle(3);
    #1 chk(oeB, 4'h2);
    chk(rdata & 32'hFFFF_00FF, 32'hAA22_0044);
    idle(1);
    #1 chk(oeB, 4'hF);
    $display("t_mask done");
  endtask
  task automatic pd(input logic [3:0] c, input logic [1:0] want);
    u_ctrl_model.cmd(c, 2'h2, 12'h400, 4'h0, 32'h0000_0000, 1'b0);
    idle(1);
    #1 chk(pwr, want);
    idle(2);
    #1 chk(pwr, 2'h0);
  endtask
  task automatic t_pwr();
    pd(4'hF, 2'h1);
    go(4'h5, 2'h2, 12'h0FF, 4'h0, 32'h0000_0000);
    pd(4'hF, 2'h2);
    go(4'h2, 2'h0, 12'h400, 4'hF, 32'h0000_0000);
    pd(4'h1, 2'h3);
    $display("t_pwr done");
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #20000;
    failures++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    t_bank();
    t_mask();
    t_pwr();
    close_out();
  end
endmodule
`default_nettype wire
